//--- hdl/dbgeh_pkg.sv
// constants and state codes for the debug entry handshake block
package dbgeh_pkg;
    // ------------------------------------------------------------------
    // link framing, fixed and never configurable
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned BAUD        = 9600;
    localparam int unsigned DATA_BITS   = 8;
    localparam int unsigned STOP_BITS   = 1;
    // start + data + stop
    localparam int unsigned FRAME_BITS  = 1 + DATA_BITS + STOP_BITS;

    // ------------------------------------------------------------------
    // probe and acknowledge bytes
    // ------------------------------------------------------------------
    localparam logic [7:0]  PROBE_BYTE  = 8'h00;
    localparam logic [7:0]  ACK_BYTE    = 8'h4f;

    // ------------------------------------------------------------------
    // timing: window in ms, cycle counts derived from the clock rate
    // ------------------------------------------------------------------
    localparam int unsigned WINDOW_MS   = 500;
    localparam int unsigned MS_PER_S    = 1000;
    // longest time, rounded down by integer division
    localparam int unsigned WINDOW_CYC  = (CLK_HZ / MS_PER_S) * WINDOW_MS;
    localparam int unsigned BIT_CYC     = CLK_HZ / BAUD;

    // ------------------------------------------------------------------
    // entry states, gray coded along probe -> wait -> outcome
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DBGEH_ST_BOOT   = 3'h0,
        DBGEH_ST_PROBE  = 3'h1,
        DBGEH_ST_WAIT   = 3'h3,
        DBGEH_ST_NORMAL = 3'h2,
        DBGEH_ST_DEBUG  = 3'h7
    } dbgeh_state_e;
endpackage : dbgeh_pkg

//--- hdl/dbgeh_top.sv
// boot-time debug entry handshake on the asynchronous debug link
//
// Contract
// - after self-test, send one zero probe byte
// - debug mode only if ack inside 500 ms
// - acknowledge byte must be ASCII O
// - debug entry halts further script execution
// - link fixed at 9600 8N1, not configurable
// - redirect option moves debug to application connector
// - redirect change needs reboot; one run to undo
// - redirected: no application serial send/receive commands
// - dedicated-port debug: no extension card commands
`timescale 1ns/1ps
`default_nettype none

module dbgeh_top #(
    parameter int unsigned P_BIT_CYC = dbgeh_pkg::BIT_CYC,
    parameter int unsigned P_WIN_CYC = dbgeh_pkg::WINDOW_CYC
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_selftest_done,
    input  wire logic i_debug_rx,
    input  wire logic i_app_rx,
    input  wire logic i_redirect_cfg,
    input  wire logic i_redirect_record,
    input  wire logic i_script_pass_done,
    output logic      o_debug_tx,
    output logic      o_app_tx,
    output logic      o_app_tx_owned,
    output logic      o_entry_done,
    output logic      o_debug_mode,
    output logic      o_halt_script,
    output logic      o_normal_start,
    output logic      o_debug_on_app,
    output logic      o_app_serial_cmd_en,
    output logic      o_ext_card_cmd_en,
    output logic      o_redirect_record
);
    // ------------------------------------------------------------------
    // sizes and elaboration checks
    // ------------------------------------------------------------------
    localparam int unsigned BW = $clog2(P_BIT_CYC + 1);
    localparam int unsigned WW = $clog2(P_WIN_CYC + 1);
    localparam logic [BW-1:0] BIT_LAST  = BW'(P_BIT_CYC - 1);
    localparam logic [BW-1:0] BIT_HALF  = BW'(P_BIT_CYC / 2);
    localparam logic [WW-1:0] WIN_LAST  = WW'(P_WIN_CYC - 1);
    localparam logic [3:0]    FRM_LAST  = 4'(dbgeh_pkg::FRAME_BITS - 1);

    // mid-bit sampling needs a few cycles per bit
    if (P_BIT_CYC < 4) begin : g_bad_bit
        $error("dbgeh_top: P_BIT_CYC below 4");
    end
    if (P_WIN_CYC < 1) begin : g_bad_win
        $error("dbgeh_top: P_WIN_CYC below 1");
    end

    // ------------------------------------------------------------------
    // pin synchronisers, two flops per receive line
    // ------------------------------------------------------------------
    logic [1:0] rx_pin;
    logic [1:0] rx_meta_r;
    logic [1:0] rx_sync_r;
    assign rx_pin = {i_app_rx, i_debug_rx};

    // one generate per line; first flop read only by the second
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge i_clk_sys) begin
            if (!i_rst_n) begin
                rx_meta_r[g] <= 1'b1;
                rx_sync_r[g] <= 1'b1;
            end else begin
                rx_meta_r[g] <= rx_pin[g];
                rx_sync_r[g] <= rx_meta_r[g];
            end
        end
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    dbgeh_pkg::dbgeh_state_e state_r, state_nxt;
    logic          redir_r,     redir_nxt;
    logic          cfg_boot_r,  cfg_boot_nxt;
    logic          record_r,    record_nxt;
    logic [WW-1:0] win_r,       win_nxt;
    logic [9:0]    tx_shift_r,  tx_shift_nxt;
    logic [3:0]    tx_bit_r,    tx_bit_nxt;
    logic [BW-1:0] tx_baud_r,   tx_baud_nxt;
    logic          tx_line_r,   tx_line_nxt;
    logic          rx_busy_r,   rx_busy_nxt;
    logic [3:0]    rx_bit_r,    rx_bit_nxt;
    logic [BW-1:0] rx_baud_r,   rx_baud_nxt;
    logic [7:0]    rx_shift_r,  rx_shift_nxt;
    logic          rx_line;
    logic          rx_done;
    logic          rx_good;

    // receive from whichever connector carries debug this boot
    assign rx_line = redir_r ? rx_sync_r[1] : rx_sync_r[0];

    // ------------------------------------------------------------------
    // next-state logic: entry sequence, probe sender, ack receiver
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        redir_nxt    = redir_r;
        cfg_boot_nxt = cfg_boot_r;
        record_nxt   = record_r;
        win_nxt      = win_r;
        tx_shift_nxt = tx_shift_r;
        tx_bit_nxt   = tx_bit_r;
        tx_baud_nxt  = tx_baud_r;
        tx_line_nxt  = tx_line_r;
        rx_busy_nxt  = rx_busy_r;
        rx_bit_nxt   = rx_bit_r;
        rx_baud_nxt  = rx_baud_r;
        rx_shift_nxt = rx_shift_r;
        rx_done      = 1'b0;
        rx_good      = 1'b0;

        // receiver: 8N1, sampled mid-bit, listens only in the window
        if (state_r != dbgeh_pkg::DBGEH_ST_WAIT) begin
            rx_busy_nxt = 1'b0;
        end else if (!rx_busy_r) begin
            if (!rx_line) begin // start edge
                rx_busy_nxt = 1'b1;
                rx_bit_nxt  = 4'h0;
                rx_baud_nxt = BIT_HALF;
            end
        end else if (rx_baud_r != '0) begin
            rx_baud_nxt = rx_baud_r - BW'(1);
        end else begin
            rx_baud_nxt = BIT_LAST;
            rx_bit_nxt  = rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0) begin
                // glitch, not a start bit: drop it
                rx_busy_nxt = ~rx_line;
            end else if (rx_bit_r == FRM_LAST) begin
                rx_busy_nxt = 1'b0;
                rx_done     = 1'b1;
                // stop bit must be high for a valid byte
                rx_good = rx_line && (rx_shift_r == dbgeh_pkg::ACK_BYTE);
            end else begin
                rx_shift_nxt = {rx_line, rx_shift_r[7:1]}; // lsb first
            end
        end

        // transmitter: shifts the probe frame out lsb first
        if (state_r == dbgeh_pkg::DBGEH_ST_PROBE) begin
            if (tx_baud_r != '0) begin
                tx_baud_nxt = tx_baud_r - BW'(1);
            end else begin
                tx_baud_nxt  = BIT_LAST;
                tx_line_nxt  = tx_shift_r[0];
                tx_shift_nxt = {1'b1, tx_shift_r[9:1]};
                tx_bit_nxt   = tx_bit_r + 4'h1;
            end
        end

        // entry sequence
        case (state_r)
            dbgeh_pkg::DBGEH_ST_BOOT: begin
                if (i_selftest_done) begin
                    state_nxt    = dbgeh_pkg::DBGEH_ST_PROBE;
                    // option only sampled here, so changes need a reboot
                    cfg_boot_nxt = i_redirect_cfg;
                    redir_nxt    = i_redirect_cfg | i_redirect_record;
                    record_nxt   = i_redirect_cfg | i_redirect_record;
                    tx_shift_nxt = {1'b1, dbgeh_pkg::PROBE_BYTE, 1'b0};
                    tx_bit_nxt   = 4'h0;
                    tx_baud_nxt  = '0;
                end
            end
            dbgeh_pkg::DBGEH_ST_PROBE: begin
                // window opens once the stop bit has fully gone out
                if (tx_bit_r == FRM_LAST + 4'h1 && tx_baud_r == '0) begin
                    state_nxt = dbgeh_pkg::DBGEH_ST_WAIT;
                    win_nxt   = '0;
                end
            end
            dbgeh_pkg::DBGEH_ST_WAIT: begin
                win_nxt = win_r + WW'(1);
                if (rx_done && rx_good) begin
                    state_nxt = dbgeh_pkg::DBGEH_ST_DEBUG;
                end else if (rx_done) begin
                    state_nxt = dbgeh_pkg::DBGEH_ST_NORMAL;
                end else if (win_r == WIN_LAST) begin
                    state_nxt = dbgeh_pkg::DBGEH_ST_NORMAL;
                end
            end
            dbgeh_pkg::DBGEH_ST_NORMAL: begin
                // one completed run without the option undoes the redirect
                if (i_script_pass_done && !cfg_boot_r) begin
                    record_nxt = 1'b0;
                end
            end
            default: begin
                // debug mode holds until the next reset
                state_nxt = state_r;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_r    <= dbgeh_pkg::DBGEH_ST_BOOT;
            redir_r    <= 1'b0;
            cfg_boot_r <= 1'b0;
            record_r   <= 1'b0;
            win_r      <= '0;
            tx_shift_r <= '1;
            tx_bit_r   <= 4'h0;
            tx_baud_r  <= '0;
            tx_line_r  <= 1'b1;
            rx_busy_r  <= 1'b0;
            rx_bit_r   <= 4'h0;
            rx_baud_r  <= '0;
            rx_shift_r <= 8'h00;
        end else begin
            state_r    <= state_nxt;
            redir_r    <= redir_nxt;
            cfg_boot_r <= cfg_boot_nxt;
            record_r   <= record_nxt;
            win_r      <= win_nxt;
            tx_shift_r <= tx_shift_nxt;
            tx_bit_r   <= tx_bit_nxt;
            tx_baud_r  <= tx_baud_nxt;
            tx_line_r  <= tx_line_nxt;
            rx_busy_r  <= rx_busy_nxt;
            rx_bit_r   <= rx_bit_nxt;
            rx_baud_r  <= rx_baud_nxt;
            rx_shift_r <= rx_shift_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs: link pins and mode/permission levels
    // ------------------------------------------------------------------
    // idle line high on the connector not carrying debug
    assign o_debug_tx     = redir_r ? 1'b1 : tx_line_r;
    assign o_app_tx       = redir_r ? tx_line_r : 1'b1;
    assign o_app_tx_owned = redir_r;

    // mode levels straight from the state flops
    assign o_debug_mode   = (state_r == dbgeh_pkg::DBGEH_ST_DEBUG);
    assign o_halt_script  = o_debug_mode;
    assign o_normal_start = (state_r == dbgeh_pkg::DBGEH_ST_NORMAL);
    assign o_entry_done   = o_debug_mode | o_normal_start;
    assign o_debug_on_app = redir_r;
    assign o_redirect_record = record_r;

    // redirected debug owns the application port
    assign o_app_serial_cmd_en = ~redir_r;
    // extension card traffic only blocked when debugging on own port
    assign o_ext_card_cmd_en = ~(o_debug_mode & ~redir_r);
endmodule : dbgeh_top

`default_nettype wire

//--- testbench/dbgeh_host_model.sv
// behavioural host debugger on the far side of the debug link
`timescale 1ns/1ps
`default_nettype none
module dbgeh_host_model #(
    parameter int P_BIT = 8
) (
    input  wire logic       i_clk,
    input  wire logic       i_line,
    input  wire logic       i_go,
    input  wire logic [7:0] i_byte,
    output logic            o_line,
    output logic [7:0]      o_probe
);
    // ------------------------------------------------------------
    // catch the probe, then answer after its stop bit
    // ------------------------------------------------------------
    // plain 8n1, no flow control lines exist at all
    always begin
        o_line = 1'b1;
        do @(negedge i_clk); while (!(i_go === 1'b1 && i_line === 1'b0));
        repeat (P_BIT / 2) @(negedge i_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (P_BIT) @(negedge i_clk);
            o_probe[i] = i_line;
        end
        // small margin so the ack never overlaps the probe stop bit
        repeat (P_BIT + P_BIT / 2 + 2) @(negedge i_clk);
        o_line = 1'b0;
        for (int i = 0; i < 9; i++) begin
            repeat (P_BIT) @(negedge i_clk);
            o_line = (i < 8) ? i_byte[i] : 1'b1;
        end
        repeat (P_BIT) @(negedge i_clk);
    end
endmodule : dbgeh_host_model
`default_nettype wire

//--- testbench/dbgeh_top_sva.sv
// assertion checker for the debug entry handshake block
`timescale 1ns/1ps
`default_nettype none
module dbgeh_top_sva #(
    parameter int unsigned P_BIT_CYC = dbgeh_pkg::BIT_CYC,
    parameter int unsigned P_WIN_CYC = dbgeh_pkg::WINDOW_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_selftest_done,
    input wire logic i_debug_rx,
    input wire logic i_app_rx,
    input wire logic i_redirect_cfg,
    input wire logic i_redirect_record,
    input wire logic i_script_pass_done,
    input wire logic o_debug_tx,
    input wire logic o_app_tx,
    input wire logic o_app_tx_owned,
    input wire logic o_entry_done,
    input wire logic o_debug_mode,
    input wire logic o_halt_script,
    input wire logic o_normal_start,
    input wire logic o_debug_on_app,
    input wire logic o_app_serial_cmd_en,
    input wire logic o_ext_card_cmd_en,
    input wire logic o_redirect_record
);
    // ------------------------------------------------------------
    // mode outputs and pins; bit time is at least 8 cycles
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    AST_HALT_FOLLOWS: assert property (o_halt_script == o_debug_mode)
        else $error("halt differs from debug mode");
    AST_ONE_OUTCOME: assert property (!(o_debug_mode && o_normal_start))
        else $error("debug and normal both set");
    AST_DONE_DECODE: assert property
        (o_entry_done == (o_debug_mode || o_normal_start))
        else $error("entry done not tied to outcome");
    AST_DEBUG_FINAL: assert property (o_debug_mode |=> o_debug_mode)
        else $error("debug mode dropped");
    AST_NORMAL_FINAL: assert property (o_normal_start |=> o_normal_start)
        else $error("normal start dropped");
    AST_PROBE_LOW: assert property ($fell(o_debug_tx) |-> !o_debug_tx [*8])
        else $error("debug probe start bit too short");
    AST_APP_PROBE_LOW: assert property ($fell(o_app_tx) |-> !o_app_tx [*8])
        else $error("app probe start bit too short");
    AST_DEBUG_PIN_IDLE: assert property (o_debug_on_app |-> o_debug_tx)
        else $error("debug pin used while redirected");
    AST_APP_PIN_IDLE: assert property (!o_app_tx_owned |-> o_app_tx)
        else $error("app pin driven while not owned");
    AST_APP_CMD_GATE: assert property
        (o_app_serial_cmd_en == !o_debug_on_app)
        else $error("app command enable wrong");
    AST_EXT_CMD_GATE: assert property
        (o_ext_card_cmd_en == !(o_debug_mode && !o_debug_on_app))
        else $error("extension command enable wrong");
    AST_ROUTE_STEADY: assert property
        (o_entry_done |=> $stable(o_debug_on_app))
        else $error("redirect changed without reboot");
    // pin seen three edges back is the synced stop sample
    AST_STOP_HIGH: assert property
        ($rose(o_debug_mode) |-> (o_debug_on_app ? $past(i_app_rx, 3)
                                                : $past(i_debug_rx, 3)))
        else $error("debug entered without high stop bit");
endmodule : dbgeh_top_sva
`default_nettype wire
bind dbgeh_top dbgeh_top_sva #(.P_BIT_CYC(P_BIT_CYC), .P_WIN_CYC(P_WIN_CYC))
    chk_u (.*);

//--- testbench/dbgeh_top_tb.sv
// self-checking testbench for the debug entry handshake block
`timescale 1ns/1ps
`default_nettype none
module dbgeh_top_tb;
    // ------------------------------------------------------------
    // clock, design and host model
    // ------------------------------------------------------------
    logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_selftest_done = 1'b0;
    logic i_redirect_cfg = 1'b0, i_redirect_record = 1'b0;
    logic i_script_pass_done = 1'b0, go = 1'b0, use_app = 1'b0;
    logic [7:0] ack = 8'h4f, probe;
    logic host_tx, i_debug_rx, i_app_rx, o_debug_tx, o_app_tx;
    logic o_app_tx_owned, o_entry_done, o_debug_mode, o_halt_script;
    logic o_normal_start, o_debug_on_app, o_app_serial_cmd_en;
    logic o_ext_card_cmd_en, o_redirect_record;
    int fail_count = 0, num_checks = 0, boot_cyc = 0;

    // short bit and window counts keep each boot under 500 cycles
    localparam int BIT_T = 8;
    localparam int WIN_T = 400;
    // one edge takes self-test, one launches the start bit
    localparam int DECIDE_T = 2 + dbgeh_pkg::FRAME_BITS * BIT_T + WIN_T;
    always #12.5 i_clk_sys = ~i_clk_sys;
    assign i_debug_rx = use_app ? 1'b1 : host_tx;
    assign i_app_rx = use_app ? host_tx : 1'b1;
    dbgeh_top #(.P_BIT_CYC(BIT_T), .P_WIN_CYC(WIN_T)) dut_u (.*);
    dbgeh_host_model #(.P_BIT(BIT_T)) host_u (.i_clk(i_clk_sys),
        .i_line(use_app ? o_app_tx : o_debug_tx), .i_go(go),
        .i_byte(ack), .o_line(host_tx), .o_probe(probe));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // reboot with the given options and wait for the decision
    task automatic boot(input logic c, input logic r, input logic g,
                        input logic [7:0] b);
        int n;
        @(negedge i_clk_sys);
        {i_rst_n, i_selftest_done, go, ack} = {2'b00, g, b};
        {i_redirect_cfg, i_redirect_record, use_app} = {c, r, c | r};
        repeat (12) @(negedge i_clk_sys);
        {i_rst_n, i_selftest_done} = 2'b11;
        n = 0;
        while (o_entry_done !== 1'b1 && n < 2000) begin
            @(negedge i_clk_sys);
            n++;
        end
        boot_cyc = n;
        check("entry_done", o_entry_done, 8'h01);
    endtask : boot

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_ack_dedicated();
        boot(1'b0, 1'b0, 1'b1, 8'h4f);
        check("probe", probe, 8'h00);
        check("debug_mode", o_debug_mode, 8'h01);
        check("halt", o_halt_script, 8'h01);
        check("ext_en", o_ext_card_cmd_en, 8'h00);
        check("app_en", o_app_serial_cmd_en, 8'h01);
        check("app_owned", o_app_tx_owned, 8'h00);
        check("in_window", boot_cyc < DECIDE_T, 8'h01);
    endtask : t_ack_dedicated

    task automatic t_wrong_byte();
        boot(1'b0, 1'b0, 1'b1, 8'h6f);
        check("normal", o_normal_start, 8'h01);
        check("debug_mode", o_debug_mode, 8'h00);
    endtask : t_wrong_byte

    task automatic t_no_ack();
        boot(1'b0, 1'b0, 1'b0, 8'h4f);
        check("normal", o_normal_start, 8'h01);
        check("halt", o_halt_script, 8'h00);
        check("window", boot_cyc, DECIDE_T);
    endtask : t_no_ack

    // option still set: a finished run must not clear the record
    task automatic t_keep();
        boot(1'b1, 1'b0, 1'b0, 8'h4f);
        check("window", boot_cyc, DECIDE_T);
        check("normal", o_normal_start, 8'h01);
        i_script_pass_done = 1'b1;
        @(negedge i_clk_sys);
        i_script_pass_done = 1'b0;
        @(negedge i_clk_sys);
        check("record", o_redirect_record, 8'h01);
    endtask : t_keep

    task automatic t_redirect();
        boot(1'b1, 1'b0, 1'b1, 8'h4f);
        check("probe", probe, 8'h00);
        check("debug_mode", o_debug_mode, 8'h01);
        check("on_app", o_debug_on_app, 8'h01);
        check("app_en", o_app_serial_cmd_en, 8'h00);
        check("ext_en", o_ext_card_cmd_en, 8'h01);
        check("record", o_redirect_record, 8'h01);
        check("app_owned", o_app_tx_owned, 8'h01);
        // option dropped mid-run: route must hold until reboot
        i_redirect_cfg = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        check("on_app", o_debug_on_app, 8'h01);
    endtask : t_redirect

    // option removed: one normal run is needed before it clears
    task automatic t_undo();
        boot(1'b0, 1'b1, 1'b0, 8'h4f);
        check("on_app", o_debug_on_app, 8'h01);
        check("record", o_redirect_record, 8'h01);
        i_script_pass_done = 1'b1;
        @(negedge i_clk_sys);
        i_script_pass_done = 1'b0;
        @(negedge i_clk_sys);
        check("record", o_redirect_record, 8'h00);
        boot(1'b0, 1'b0, 1'b1, 8'h4f);
        check("on_app", o_debug_on_app, 8'h00);
        check("debug_mode", o_debug_mode, 8'h01);
    endtask : t_undo

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        t_ack_dedicated();
        t_wrong_byte();
        t_no_ack();
        t_keep();
        t_redirect();
        t_undo();
        summarize();
    end

    // seven boots of under 500 cycles each fit well inside this
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        fail_count++;
        summarize();
    end
endmodule : dbgeh_top_tb
`default_nettype wire
